/* efb_frame_builder.sv */
/*
 Emergency frame builder: turns one error event into an 8-byte emergency
 frame, and sends one boot-up frame after every reset.
 Assumes the CAN controller holds tx_ready low while busy, and that the event
 source holds ev_valid with its fields until ev_ready.
*/
module efb_frame_builder
   import efb_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Node configuration
   input wire logic [6:0] node_id,
   // Error events
   input wire logic ev_valid,
   input efb_event_type ev_kind,
   input wire logic [7:0] ev_module,
   input wire logic [7:0] ev_channel,
   input wire logic [7:0] ev_detail,
   input wire logic [63:0] ev_diag,
   input wire logic ev_gateway,
   output logic ev_ready,
   // Frame to the CAN controller
   output logic tx_valid,
   input wire logic tx_ready,
   output logic [10:0] tx_id,
   output logic [3:0] tx_dlc,
   output logic [63:0] tx_data
);
   // ==========================================================
   // Frame composition
   // Byte n of the frame sits at tx_data[8n+7:8n]
   function automatic logic [63:0] compose(
      input efb_event_type kind,
      input logic [7:0] md,
      input logic [7:0] ch,
      input logic [7:0] dt,
      input logic [63:0] dg,
      input logic gw);
      logic [15:0] code;
      logic [7:0] er;
      logic [7:0] b3;
      logic [7:0] b4;
      logic [7:0] b5;
      logic [7:0] b6;
      logic [7:0] b7;
      logic [7:0] mdz;
      logic [7:0] chz;
      code = CODE_RESET;
      er = ERR_REG_NONE;
      b3 = ZERO_BYTE;
      b4 = ZERO_BYTE;
      b5 = ZERO_BYTE;
      b6 = ZERO_BYTE;
      b7 = ZERO_BYTE;
      mdz = gw ? ZERO_BYTE : md;
      chz = gw ? ZERO_BYTE : ch;
      case (kind)
         EV_SUPPLY_HIGH: begin
            code = CODE_SUPPLY_HIGH;
            er[ERB_VOLTAGE] = 1'b1;
            b4 = chz;
         end
         EV_SUPPLY_LOW: begin
            code = CODE_SUPPLY_LOW;
            er[ERB_VOLTAGE] = 1'b1;
            b3 = mdz;
            b4 = chz;
         end
         EV_FIELD_LOW: begin
            code = CODE_FIELD_LOW;
            er[ERB_VOLTAGE] = 1'b1;
            b3 = mdz;
            b4 = chz;
         end
         EV_ENCODER, EV_SERIAL: begin
            // Detail byte is the caller's fault code, passed as is
            code = CODE_MODULE;
            er[ERB_MANUFACTURER] = 1'b1;
            b3 = mdz;
            b4 = chz;
            b5 = dt;
         end
         EV_CNT_GENERAL, EV_CNT_DIAG: begin
            code = (kind == EV_CNT_GENERAL) ? CODE_CNT_GENERAL : CODE_CNT_DIAG;
            er[ERB_GENERIC] = 1'b1;
            er[ERB_MANUFACTURER] = 1'b1;
            b3 = mdz;
         end
         EV_LIST_ADAPT, EV_LIST_INCOMPAT, EV_LIST_EXPAND, EV_LIST_REMOVED: begin
            case (kind)
               EV_LIST_ADAPT: code = CODE_LIST_ADAPT;
               EV_LIST_INCOMPAT: code = CODE_LIST_INCOMPAT;
               EV_LIST_EXPAND: code = CODE_LIST_EXPAND;
               default: code = CODE_LIST_REMOVED;
            endcase
            er[ERB_MANUFACTURER] = 1'b1;
            b3 = mdz;
         end
         EV_GUARD_FAIL: begin
            code = CODE_GUARD_FAIL;
            er[ERB_COMM] = 1'b1;
         end
         EV_BUSOFF_LEFT: begin
            code = CODE_BUSOFF_LEFT;
            er[ERB_COMM] = 1'b1;
         end
         EV_FORCED_OUTPUT: begin
            code = CODE_FORCED_OUTPUT;
            er[ERB_MANUFACTURER] = 1'b1;
         end
         EV_ONEWIRE: begin
            code = CODE_MODULE;
            er[ERB_MANUFACTURER] = 1'b1;
            b3 = mdz;
            b4 = dg[7:0];
            b5 = dg[15:8];
            b6 = dg[23:16] | dg[39:32] | dg[55:48];
            b7 = dg[31:24] | dg[47:40] | dg[63:56];
         end
         EV_ERROR_RESET: begin
            code = CODE_RESET;
         end
         default: begin
            code = CODE_RESET;
         end
      endcase
      // Low byte of the code goes out first
      compose = {b7, b6, b5, b4, b3, er, code[15:8], code[7:0]};
   endfunction

   // ==========================================================
   // Sequencer
   typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_SEND} efb_state_type;
   efb_state_type state_r;
   logic [63:0] frame;
   logic tx_take;
   assign frame = compose(ev_kind, ev_module, ev_channel, ev_detail, ev_diag, ev_gateway);
   assign tx_take = tx_valid && tx_ready;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_r <= ST_BOOT;
      end else begin
         case (state_r)
            ST_BOOT: if (tx_take) state_r <= ST_IDLE;
            ST_IDLE: if (ev_valid) state_r <= ST_SEND;
            ST_SEND: if (tx_take) state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Boot-up frame is held from reset until taken, so nothing can overtake it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_valid <= 1'b0;
         tx_id <= GUARD_ID_BASE;
         tx_dlc <= BOOT_DLC;
         tx_data <= FRAME_ZERO;
         ev_ready <= 1'b0;
      end else begin
         ev_ready <= 1'b0;
         if (state_r == ST_BOOT && !tx_valid) begin
            tx_valid <= 1'b1;
            tx_id <= GUARD_ID_BASE + {4'h0, node_id};
            tx_dlc <= BOOT_DLC;
            tx_data <= {56'h0, BOOT_DATA};
         end else if (state_r == ST_IDLE && ev_valid && !ev_ready) begin
            tx_valid <= 1'b1;
            tx_id <= EMCY_ID_BASE + {4'h0, node_id};
            tx_dlc <= EMCY_DLC;
            tx_data <= frame;
            ev_ready <= 1'b1;
         end else if (tx_take) begin
            tx_valid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Checks
   supply_high_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && ev_valid && !ev_ready && ev_kind == EV_SUPPLY_HIGH)
      |=> (tx_data[15:0] == 16'h3110 && tx_data[18] && tx_data[31:24] == 8'h00))
      else $error("supply high frame wrong");
   gateway_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && ev_valid && !ev_ready && ev_gateway)
      |=> (tx_data[31:24] == 8'h00
          && (tx_data[39:32] == 8'h00 || $past(ev_kind) == EV_ONEWIRE)))
      else $error("gateway error carries module or channel");
   onewire_or_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && ev_valid && !ev_ready && ev_kind == EV_ONEWIRE)
      |=> (tx_data[55:48] == ($past(ev_diag[23:16]) | $past(ev_diag[39:32])
          | $past(ev_diag[55:48]))))
      else $error("one-wire byte 6 not ORed");
   tail_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && ev_valid && !ev_ready && ev_kind != EV_ONEWIRE)
      |=> (tx_data[63:48] == 16'h0000))
      else $error("bytes 6 and 7 not zero");
   emcy_id_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ST_SEND && tx_valid) |-> (tx_id == 11'd128 + {4'h0, node_id}
      && tx_dlc == 4'h8))
      else $error("emergency identifier or length wrong");
   boot_first_a: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> ##1 (tx_valid && tx_dlc == 4'h1 && tx_data[7:0] == 8'h00))
      else $error("boot-up frame missing after reset");
   hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data) && $stable(tx_id)))
      else $error("frame changed while stalled");
   reset_code_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && ev_valid && !ev_ready && ev_kind == EV_ERROR_RESET)
      |=> (tx_data == 64'h0))
      else $error("error reset frame not zero");
   comm_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
      (state_r == ST_IDLE && ev_valid && !ev_ready && ev_kind == EV_GUARD_FAIL)
      |=> (tx_data[23:0] == 24'h108130))
      else $error("guarding failure frame wrong");
endmodule

/* efb_pkg.sv */
/*
 Shared constants of the emergency frame builder: event kinds, error codes,
 error register bits, identifier bases and frame layout.
 Assumes a CAN controller that accepts one frame at a time on a valid/ready pair.
*/
package efb_pkg;
   // ==========================================================
   // Event kinds
   typedef enum logic [4:0] {
      EV_SUPPLY_HIGH, EV_SUPPLY_LOW, EV_FIELD_LOW, EV_ENCODER, EV_SERIAL,
      EV_CNT_GENERAL, EV_CNT_DIAG, EV_LIST_ADAPT, EV_LIST_INCOMPAT,
      EV_LIST_EXPAND, EV_LIST_REMOVED, EV_GUARD_FAIL, EV_BUSOFF_LEFT,
      EV_FORCED_OUTPUT, EV_ONEWIRE, EV_ERROR_RESET
   } efb_event_type;
   // ==========================================================
   // Error codes
   localparam logic [15:0] CODE_RESET = 16'h0000;
   localparam logic [15:0] CODE_SUPPLY_HIGH = 16'h3110;
   localparam logic [15:0] CODE_SUPPLY_LOW = 16'h3120;
   localparam logic [15:0] CODE_FIELD_LOW = 16'h3320;
   localparam logic [15:0] CODE_MODULE = 16'h7000;
   localparam logic [15:0] CODE_CNT_GENERAL = 16'h7010;
   localparam logic [15:0] CODE_CNT_DIAG = 16'h7011;
   localparam logic [15:0] CODE_LIST_ADAPT = 16'h707A;
   localparam logic [15:0] CODE_LIST_INCOMPAT = 16'h707D;
   localparam logic [15:0] CODE_LIST_EXPAND = 16'h707E;
   localparam logic [15:0] CODE_LIST_REMOVED = 16'h707F;
   localparam logic [15:0] CODE_GUARD_FAIL = 16'h8130;
   localparam logic [15:0] CODE_BUSOFF_LEFT = 16'h8140;
   localparam logic [15:0] CODE_FORCED_OUTPUT = 16'h9009;
   // ==========================================================
   // Error register bits
   localparam int ERB_GENERIC = 0;
   localparam int ERB_CURRENT = 1;
   localparam int ERB_VOLTAGE = 2;
   localparam int ERB_TEMPERATURE = 3;
   localparam int ERB_COMM = 4;
   localparam int ERB_PROFILE = 5;
   localparam int ERB_MANUFACTURER = 7;
   localparam logic [7:0] ERR_REG_NONE = 8'h00;
   // ==========================================================
   // Identifiers and frame layout
   localparam logic [10:0] EMCY_ID_BASE = 11'h080;
   localparam logic [10:0] GUARD_ID_BASE = 11'h700;
   localparam logic [3:0] EMCY_DLC = 4'h8;
   localparam logic [3:0] BOOT_DLC = 4'h1;
   localparam logic [7:0] BOOT_DATA = 8'h00;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [6:0] NODE_ID_RESET = 7'h00;
   localparam logic [63:0] FRAME_ZERO = 64'h0000_0000_0000_0000;
endpackage

/* efb_can_sink.sv */
/*
 CAN controller stand-in for the emergency frame builder bench.
 Assumes frames arrive on a valid/ready pair clocked by sys_clk.
*/
module efb_can_sink (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Frame from the builder
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [10:0] tx_id,
   input wire logic [3:0] tx_dlc,
   input wire logic [63:0] tx_data,
   // Bench control and capture
   input wire logic [3:0] delay,
   output logic [15:0] n_frames,
   output logic [10:0] got_id,
   output logic [3:0] got_dlc,
   output logic [63:0] got_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_r;
   // ==========================================================
   // Acceptance
   // Ready comes only after delay cycles, as a busy controller would give it
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tx_ready <= 1'b0;
         wait_r <= 4'h0;
         n_frames <= 16'h0000;
      end else if (tx_valid && tx_ready) begin
         tx_ready <= 1'b0;
         wait_r <= 4'h0;
         n_frames <= n_frames + 16'h0001;
         got_id <= tx_id;
         got_dlc <= tx_dlc;
         got_data <= tx_data;
      end else if (tx_valid && wait_r >= delay) begin
         tx_ready <= 1'b1;
      end else if (tx_valid) begin
         wait_r <= wait_r + 4'h1;
      end
   end
endmodule

/* tb.sv */
/*
 Self-checking bench of the emergency frame builder.
 Assumes efb_can_sink stands in for the CAN controller.
*/
module tb
   import efb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0, rst = 1'b1, ev_valid = 1'b0, ev_gateway = 1'b0;
   logic ev_ready, tx_valid, tx_ready;
   logic [6:0] node_id = 7'h2A;
   efb_event_type ev_kind = EV_SUPPLY_HIGH;
   logic [7:0] ev_module = 8'h00, ev_channel = 8'h00, ev_detail = 8'h00;
   logic [63:0] ev_diag = 64'h0, tx_data, got_data;
   logic [10:0] tx_id, got_id;
   logic [3:0] tx_dlc, got_dlc, delay = 4'h0;
   logic [15:0] n_frames;
   int n_mismatch = 0, checks_done = 0;
   localparam logic [63:0] DG = 64'h8001_4002_2004_1008;
   always #10 sys_clk = ~sys_clk;
   efb_frame_builder i_efb_frame_builder (.sys_clk(sys_clk), .rst(rst), .node_id(node_id),
      .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_module(ev_module), .ev_channel(ev_channel),
      .ev_detail(ev_detail), .ev_diag(ev_diag), .ev_gateway(ev_gateway), .ev_ready(ev_ready),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data));
   efb_can_sink i_efb_can_sink (.sys_clk(sys_clk), .rst(rst), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_id(tx_id), .tx_dlc(tx_dlc), .tx_data(tx_data), .delay(delay),
      .n_frames(n_frames), .got_id(got_id), .got_dlc(got_dlc), .got_data(got_data));
   // ==========================================================
   // Reporting
   task automatic report_and_stop();
      $display("mismatches %0d, comparisons %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic fail(input string msg);
      $display("CHECK FAILED t=%0t %s", $time, msg);
      n_mismatch++;
   endtask
   task automatic check_frame(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] d);
      checks_done++;
      if (got_id !== id || got_dlc !== dlc || got_data !== d) fail("frame content");
   endtask
   task automatic check_flag(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) fail("ordering flag");
   endtask
   // ==========================================================
   // Expected frame, bytes 0..7 from low to high
   function automatic logic [63:0] exp_frame(input efb_event_type k, input logic [7:0] md,
      input logic [7:0] ch, input logic [7:0] dt, input logic [63:0] dg, input logic gw);
      logic [15:0] c;
      logic [7:0] er, b3, b4, b5, b6, b7;
      if (gw) md = 8'h00;
      if (gw) ch = 8'h00;
      {b3, b4, b5, b6, b7} = {md, 32'h0};
      case (k)
         EV_SUPPLY_HIGH: {c, er, b3, b4} = {16'h3110, 8'h04, 8'h00, ch};
         EV_SUPPLY_LOW: {c, er, b4} = {16'h3120, 8'h04, ch};
         EV_FIELD_LOW: {c, er, b4} = {16'h3320, 8'h04, ch};
         EV_ENCODER, EV_SERIAL: {c, er, b4, b5} = {16'h7000, 8'h80, ch, dt};
         EV_CNT_GENERAL: {c, er} = {16'h7010, 8'h81};
         EV_CNT_DIAG: {c, er} = {16'h7011, 8'h81};
         EV_LIST_ADAPT: {c, er} = {16'h707A, 8'h80};
         EV_LIST_INCOMPAT: {c, er} = {16'h707D, 8'h80};
         EV_LIST_EXPAND: {c, er} = {16'h707E, 8'h80};
         EV_LIST_REMOVED: {c, er} = {16'h707F, 8'h80};
         EV_GUARD_FAIL: {c, er, b3} = {16'h8130, 8'h10, 8'h00};
         EV_BUSOFF_LEFT: {c, er, b3} = {16'h8140, 8'h10, 8'h00};
         EV_FORCED_OUTPUT: {c, er, b3} = {16'h9009, 8'h80, 8'h00};
         EV_ONEWIRE: begin
            {c, er, b4, b5} = {16'h7000, 8'h80, dg[7:0], dg[15:8]};
            b6 = dg[23:16] | dg[39:32] | dg[55:48];
            b7 = dg[31:24] | dg[47:40] | dg[63:56];
         end
         default: {c, er, b3} = {16'h0000, 8'h00, 8'h00};
      endcase
      return {b7, b6, b5, b4, b3, er, c[15:8], c[7:0]};
   endfunction
   // ==========================================================
   // Drivers
   task automatic wait_frame();
      logic [15:0] n0;
      n0 = n_frames;
      for (int i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         if (n_frames !== n0) return;
      end
      fail("no frame");
      report_and_stop();
   endtask
   task automatic send(input efb_event_type k, input logic [7:0] md, input logic [7:0] ch,
      input logic [7:0] dt, input logic gw);
      @(posedge sys_clk);
      ev_valid <= 1'b1;
      ev_kind <= k;
      ev_module <= md;
      ev_channel <= ch;
      ev_detail <= dt;
      ev_diag <= DG;
      ev_gateway <= gw;
      for (int i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         if (ev_ready === 1'b1) begin
            ev_valid <= 1'b0;
            return;
         end
      end
      fail("event not accepted");
      report_and_stop();
   endtask
   task automatic send_check(input efb_event_type k, input logic [7:0] md, input logic [7:0] ch,
      input logic [7:0] dt, input logic gw);
      send(k, md, ch, dt, gw);
      wait_frame();
      check_frame(11'h080 + node_id, 4'h8, exp_frame(k, md, ch, dt, DG, gw));
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_boot();
      wait_frame();
      check_frame(11'h700 + node_id, 4'h1, 64'h0);
   endtask
   task automatic t_all_kinds();
      // Every event kind back to back, ready at once
      // Unused detail is non-zero so that stray bytes show up
      send_check(EV_SUPPLY_HIGH, 8'h05, 8'h30, 8'hA5, 1'b0);
      send_check(EV_SUPPLY_LOW, 8'h06, 8'h31, 8'hA5, 1'b0);
      send_check(EV_FIELD_LOW, 8'h07, 8'h32, 8'hA5, 1'b0);
      send_check(EV_ENCODER, 8'h08, 8'h33, 8'h10, 1'b0);
      send_check(EV_SERIAL, 8'h09, 8'h34, 8'h08, 1'b0);
      send_check(EV_CNT_GENERAL, 8'h0A, 8'h35, 8'hA5, 1'b0);
      send_check(EV_CNT_DIAG, 8'h0B, 8'h36, 8'hA5, 1'b0);
      send_check(EV_LIST_ADAPT, 8'h0C, 8'h37, 8'hA5, 1'b0);
      send_check(EV_LIST_INCOMPAT, 8'h0D, 8'h38, 8'hA5, 1'b0);
      send_check(EV_LIST_EXPAND, 8'h0E, 8'h39, 8'hA5, 1'b0);
      send_check(EV_LIST_REMOVED, 8'h0F, 8'h3A, 8'hA5, 1'b0);
      send_check(EV_GUARD_FAIL, 8'h10, 8'h3B, 8'hA5, 1'b0);
      send_check(EV_BUSOFF_LEFT, 8'h11, 8'h3C, 8'hA5, 1'b0);
      send_check(EV_FORCED_OUTPUT, 8'h12, 8'h3D, 8'hA5, 1'b0);
      send_check(EV_ONEWIRE, 8'h13, 8'h3E, 8'hA5, 1'b0);
      send_check(EV_ERROR_RESET, 8'h14, 8'h3F, 8'hA5, 1'b0);
   endtask
   task automatic t_gateway();
      send_check(EV_SUPPLY_LOW, 8'h07, 8'h03, 8'h00, 1'b1);
      send_check(EV_SUPPLY_HIGH, 8'h07, 8'h03, 8'h00, 1'b1);
   endtask
   task automatic t_refuse();
      logic [15:0] n0;
      delay <= 4'h6;
      send(EV_GUARD_FAIL, 8'h01, 8'h01, 8'h00, 1'b0);
      n0 = n_frames;
      // Second event waits while the first frame is held by a slow controller
      send_check(EV_BUSOFF_LEFT, 8'h02, 8'h02, 8'h00, 1'b0);
      check_flag(n_frames - n0 == 16'h0002, 1'b1);
      delay <= 4'h0;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_boot();
      t_all_kinds();
      t_gateway();
      t_refuse();
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      node_id <= 7'h01;
      rst <= 1'b0;
      t_boot();
      send_check(EV_FORCED_OUTPUT, 8'h09, 8'h09, 8'h00, 1'b0);
      report_and_stop();
   end
endmodule
